// ### core/chgcfg_pkg.sv
// constants for the charger configuration register block
package chgcfg_pkg;

  // ==========================================================
  // register map
  localparam logic [7:0] CHGCFG_TERM_OFS = 8'h04;
  localparam logic [7:0] CHGCFG_BATT_OFS = 8'h05;
  localparam logic [7:0] CHGCFG_SYS_OFS = 8'h06;
  localparam int CHGCFG_NREG = 3;
  localparam logic [7:0] CHGCFG_TERM_RST = 8'h02;
  localparam logic [7:0] CHGCFG_BATT_RST = 8'h78;
  localparam logic [7:0] CHGCFG_SYS_RST = 8'h82;
  localparam logic [7:0] CHGCFG_UNMAPPED_RD = 8'h00;

  // ==========================================================
  // field positions
  localparam int TERM_RANGE_BIT = 7;
  localparam int TERM_CODE_HI = 6;
  localparam int TERM_CODE_LO = 2;
  localparam int TERM_EN_BIT = 1;
  localparam int BATT_CODE_HI = 7;
  localparam int BATT_CODE_LO = 1;
  localparam int SYS_EN_BIT = 7;
  localparam int SYS_RANGE_SEL_HI = 6;
  localparam int SYS_RANGE_SEL_LO = 5;
  localparam int SYS_CODE_HI = 4;
  localparam int SYS_CODE_LO = 1;

  // ==========================================================
  // scaling, currents in uA and voltages in mV
  localparam logic [15:0] TERM_LO_BASE_UA = 16'h01F4; // 500 uA
  localparam logic [15:0] TERM_LO_STEP_UA = 16'h01F4; // 500 uA
  localparam logic [15:0] TERM_LO_MAX_UA = 16'h1388; // 5 mA
  localparam logic [15:0] TERM_HI_BASE_UA = 16'h1770; // 6 mA
  localparam logic [15:0] TERM_HI_STEP_UA = 16'h03E8; // 1 mA
  localparam logic [15:0] BATT_BASE_MV = 16'h0E10; // 3.6 V
  localparam logic [15:0] BATT_STEP_MV = 16'h000A; // 10 mV
  localparam logic [15:0] BATT_MAX_MV = 16'h122A; // 4.65 V
  localparam logic [15:0] SYS_R01_BASE_MV = 16'h0514; // 1.30 V
  localparam logic [15:0] SYS_R11_BASE_MV = 16'h0708; // 1.80 V
  localparam logic [15:0] SYS_STEP_MV = 16'h0064; // 100 mV
  localparam logic [1:0] SYS_RANGE_SEL_00 = 2'h0;
  localparam logic [1:0] SYS_RANGE_SEL_01 = 2'h1;
  localparam logic [1:0] SYS_RANGE_SEL_10 = 2'h2;
  localparam logic [1:0] SYS_RANGE_SEL_11 = 2'h3;

  // non-linear ranges, indexed by the output voltage code
  localparam logic [0:15][15:0] SYS_TBL_00 = {
    16'h044C, 16'h04B0, 16'h04E2, 16'h0535, 16'h0589, 16'h05DC, 16'h062F, 16'h0683,
    16'h06D6, 16'h0729, 16'h077D, 16'h07D0, 16'h0823, 16'h0877, 16'h08CA, 16'h091D};
  localparam logic [0:15][15:0] SYS_TBL_10 = {
    16'h05DC, 16'h062F, 16'h0683, 16'h06D6, 16'h0729, 16'h077D, 16'h07D0, 16'h0823,
    16'h0877, 16'h08CA, 16'h091D, 16'h0971, 16'h09C4, 16'h0A17, 16'h0A6B, 16'h0ABE};

  // ==========================================================
  // serial port
  localparam logic [6:0] CHGCFG_DEV_ADDR = 7'h2A; // arbitrary default target address

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ADDR = 4'h1,
    ST_ACK_ADDR = 4'h2,
    ST_PTR = 4'h3,
    ST_ACK_PTR = 4'h4,
    ST_WR = 4'h5,
    ST_ACK_WR = 4'h6,
    ST_RD = 4'h7,
    ST_ACK_RD = 4'h8
  } chgcfg_st_t;

endpackage

// ### core/chgcfg_regfile.sv
// three-entry configuration register store with registered read port
`timescale 1ns/1ps
`default_nettype none
module chgcfg_regfile (
  input wire logic clk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic [7:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [7:0] rd_addr,
  output logic [7:0] rd_data,
  output logic [7:0] term_reg,
  output logic [7:0] batt_reg,
  output logic [7:0] sys_reg
);
  import chgcfg_pkg::*;

  typedef struct packed {
    logic [CHGCFG_NREG-1:0][7:0] regs;
    logic [7:0] rd_data;
  } chgcfg_rf_t;

  chgcfg_rf_t s_r;
  chgcfg_rf_t s_nxt;

  // ==========================================================
  // write decode and read mux; unmapped writes drop, reads give zero
  always_comb begin
    s_nxt = s_r;
    if (wr_en) begin
      case (wr_addr)
        CHGCFG_TERM_OFS: s_nxt.regs[0] = wr_data;
        CHGCFG_BATT_OFS: s_nxt.regs[1] = wr_data;
        CHGCFG_SYS_OFS: s_nxt.regs[2] = wr_data;
        default: s_nxt.regs = s_r.regs;
      endcase
    end
    case (rd_addr)
      CHGCFG_TERM_OFS: s_nxt.rd_data = s_r.regs[0];
      CHGCFG_BATT_OFS: s_nxt.rd_data = s_r.regs[1];
      CHGCFG_SYS_OFS: s_nxt.rd_data = s_r.regs[2];
      default: s_nxt.rd_data = CHGCFG_UNMAPPED_RD;
    endcase
  end

  // ==========================================================
  // state register, power-on values
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r.regs[0] <= CHGCFG_TERM_RST;
      s_r.regs[1] <= CHGCFG_BATT_RST;
      s_r.regs[2] <= CHGCFG_SYS_RST;
      s_r.rd_data <= CHGCFG_UNMAPPED_RD;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rd_data = s_r.rd_data;
  assign term_reg = s_r.regs[0];
  assign batt_reg = s_r.regs[1];
  assign sys_reg = s_r.regs[2];

endmodule
`default_nettype wire

// ### core/chgcfg_top.sv
// charger configuration registers behind a two-wire serial target port
// Behaviour
// - termination register at 0x04 resets to 0x02: termination on, code zero.
// - bit 7 picks 500 uA steps up to 5 mA, or 1 mA steps 6-37 mA.
// - termination code bits 6..2 weigh 8,4,2,1,0.5 mA, doubled in high range.
// - current is 500 uA + code*500 uA, or 6 mA + code*1 mA.
// - low-range settings beyond 5 mA are limited to 5 mA.
// - bit 1 enables termination; resets to one.
// - termination suppressed while any loop besides CC or CV regulates.
// - an external termination resistor may override the register setting.
// - battery voltage register at 0x05 resets to 0x78.
// - bits 7..1 form a 7-bit code weighing 640 mV down to 10 mV.
// - regulation voltage is 3.6 V plus code; above 4.65 V it saturates.
// - system output register at 0x06 resets to 0x82: enabled, range 00, code 1.
// - bit 7 enables the buck output; cleared means disabled and pulled low.
// - bits 6..5 pick among four output voltage ranges.
// - bits 4..1 form a code weighing 800,400,200,100 mV in ranges 01 and 11.
// - range 01 gives 1.30 V + code*100 mV; range 11 gives 1.80 V + code*100 mV.
`timescale 1ns/1ps
`default_nettype none
module chgcfg_top #(
  parameter logic [6:0] DEV_ADDR = chgcfg_pkg::CHGCFG_DEV_ADDR
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  input wire logic cc_cv_in_control,
  input wire logic input_voltage_limit_loop,
  input wire logic cool_current_reduce,
  input wire logic ext_term_present,
  input wire logic [15:0] ext_term_ua,
  output logic [15:0] term_current_ua,
  output logic term_active,
  output logic [15:0] battery_regulation_voltage,
  output logic sys_out_enable,
  output logic sys_pull_low,
  output logic [15:0] system_rail_mv
);
  import chgcfg_pkg::*;

  // ==========================================================
  // port and set-point state in one record; register contents sit in u_regs
  typedef struct packed {
    chgcfg_st_t st;
    logic [2:0] bitn;
    logic [7:0] sh;
    logic [7:0] ptr;
    logic rw;
    logic mack;
    logic scl_q;
    logic sda_q;
    logic sda_o;
    logic sda_oe_n;
    logic wr_en;
    logic [7:0] wr_data;
    logic [15:0] term_ua;
    logic term_act;
    logic [15:0] batt_mv;
    logic sys_en;
    logic sys_pl;
    logic [15:0] sys_mv;
  } chgcfg_state_t;

  chgcfg_state_t s_r;
  chgcfg_state_t s_nxt;

  logic [7:0] rd_data;
  logic [7:0] term_reg;
  logic [7:0] batt_reg;
  logic [7:0] sys_reg;

  // register store; read data follow the pointer one cycle late,
  // which is far sooner than any serial bit period; the write pulse
  // leaves before the pointer moves, so a burst never skips a place
  chgcfg_regfile u_regs (
    .clk(clk),
    .rst(rst),
    .wr_en(s_r.wr_en),
    .wr_addr(s_r.ptr),
    .wr_data(s_r.wr_data),
    .rd_addr(s_r.ptr),
    .rd_data(rd_data),
    .term_reg(term_reg),
    .batt_reg(batt_reg),
    .sys_reg(sys_reg)
  );

  // ==========================================================
  // bus events seen against the previous sample of each pin; a start
  // or stop needs scl high on two samples, so data moving just after
  // a falling edge is never taken for one; there is no glitch filter,
  // so a noisy line must be cleaned up before it reaches the pins
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic [7:0] sh_in;

  assign scl_rise = scl_i & ~s_r.scl_q;
  assign scl_fall = ~scl_i & s_r.scl_q;
  assign bus_start = scl_i & s_r.scl_q & s_r.sda_q & ~sda_i;
  assign bus_stop = scl_i & s_r.scl_q & ~s_r.sda_q & sda_i;
  assign sh_in = {s_r.sh[6:0], sda_i};

  // ==========================================================
  // decoded fields of the stored registers
  logic term_range_sel;
  logic [4:0] term_current_code;
  logic term_enable;
  logic [6:0] batt_reg_code;
  logic [1:0] sys_range_sel;
  logic [3:0] sys_voltage_code;

  assign term_range_sel = term_reg[TERM_RANGE_BIT];
  assign term_current_code = term_reg[TERM_CODE_HI:TERM_CODE_LO];
  assign term_enable = term_reg[TERM_EN_BIT];
  assign batt_reg_code = batt_reg[BATT_CODE_HI:BATT_CODE_LO];
  assign sys_range_sel = sys_reg[SYS_RANGE_SEL_HI:SYS_RANGE_SEL_LO];
  assign sys_voltage_code = sys_reg[SYS_CODE_HI:SYS_CODE_LO];

  // ==========================================================
  // analog set-points; products are kept 16 bits wide, the largest
  // value (37 mA in uA) still fits; results are registered so the
  // analog side never sees a decode glitch while a register changes
  logic [15:0] term_lo_ua;
  logic [15:0] term_hi_ua;
  logic [15:0] batt_raw_mv;
  logic [15:0] sys_lin01_mv;
  logic [15:0] sys_lin11_mv;

  always_comb begin
    term_lo_ua = TERM_LO_BASE_UA + 16'({11'h000, term_current_code} * TERM_LO_STEP_UA);
    term_hi_ua = TERM_HI_BASE_UA + 16'({11'h000, term_current_code} * TERM_HI_STEP_UA);
    batt_raw_mv = BATT_BASE_MV + 16'({9'h000, batt_reg_code} * BATT_STEP_MV);
    sys_lin01_mv = SYS_R01_BASE_MV + 16'({12'h000, sys_voltage_code} * SYS_STEP_MV);
    sys_lin11_mv = SYS_R11_BASE_MV + 16'({12'h000, sys_voltage_code} * SYS_STEP_MV);
  end

  // ==========================================================
  // next-state logic: serial target machine plus set-point pipeline
  always_comb begin
    s_nxt = s_r;
    s_nxt.scl_q = scl_i;
    s_nxt.sda_q = sda_i;
    s_nxt.wr_en = 1'b0;
    s_nxt.sda_o = 1'b0; // open drain: only ever pulls low

    // ---- termination current, low range clamped at 5 mA; the resistor
    // replaces the current only, enable and loop gating still apply
    if (ext_term_present) begin
      s_nxt.term_ua = ext_term_ua;
    end else if (term_range_sel) begin
      s_nxt.term_ua = term_hi_ua;
    end else if (term_lo_ua > TERM_LO_MAX_UA) begin
      s_nxt.term_ua = TERM_LO_MAX_UA;
    end else begin
      s_nxt.term_ua = term_lo_ua;
    end

    // ---- termination is only trusted while CC or CV owns the charger;
    // a current held down by another loop says nothing about a full cell
    s_nxt.term_act = term_enable & cc_cv_in_control & ~input_voltage_limit_loop
                     & ~cool_current_reduce;

    // ---- battery regulation voltage saturates instead of wrapping
    if (batt_raw_mv > BATT_MAX_MV) begin
      s_nxt.batt_mv = BATT_MAX_MV;
    end else begin
      s_nxt.batt_mv = batt_raw_mv;
    end

    // ---- buck output enable and discharge
    s_nxt.sys_en = sys_reg[SYS_EN_BIT];
    s_nxt.sys_pl = ~sys_reg[SYS_EN_BIT];

    // ---- buck output voltage by range
    case (sys_range_sel)
      SYS_RANGE_SEL_00: s_nxt.sys_mv = SYS_TBL_00[sys_voltage_code];
      SYS_RANGE_SEL_01: s_nxt.sys_mv = sys_lin01_mv;
      SYS_RANGE_SEL_10: s_nxt.sys_mv = SYS_TBL_10[sys_voltage_code];
      SYS_RANGE_SEL_11: s_nxt.sys_mv = sys_lin11_mv;
      default: s_nxt.sys_mv = sys_lin01_mv;
    endcase

    // ---- serial target: start and stop override everything
    if (bus_start) begin
      s_nxt.st = ST_ADDR;
      s_nxt.bitn = 3'h0;
      s_nxt.sda_oe_n = 1'b1;
    end else if (bus_stop) begin
      s_nxt.st = ST_IDLE;
      s_nxt.sda_oe_n = 1'b1;
    end else begin
      case (s_r.st)
        ST_IDLE: begin
          s_nxt.sda_oe_n = 1'b1;
        end
        // address byte; a foreign address drops back to idle
        ST_ADDR: begin
          if (scl_rise) begin
            s_nxt.sh = sh_in;
            s_nxt.bitn = s_r.bitn + 3'h1;
            if (s_r.bitn == 3'h7) begin
              s_nxt.rw = sh_in[0];
              s_nxt.st = (sh_in[7:1] == DEV_ADDR) ? ST_ACK_ADDR : ST_IDLE;
            end
          end
        end
        // ack phases: first fall pulls low, second fall releases, or drives bit 7 after a read address;
        // the line only ever moves while scl is low
        ST_ACK_ADDR, ST_ACK_PTR, ST_ACK_WR: begin
          if (scl_fall) begin
            if (s_r.sda_oe_n) begin
              s_nxt.sda_oe_n = 1'b0;
            end else begin
              s_nxt.sda_oe_n = 1'b1;
              s_nxt.bitn = 3'h0;
              if (s_r.st == ST_ACK_ADDR && s_r.rw) begin
                s_nxt.st = ST_RD;
                s_nxt.sh = rd_data;
                s_nxt.sda_oe_n = rd_data[7];
              end else if (s_r.st == ST_ACK_ADDR) begin
                s_nxt.st = ST_PTR;
              end else begin
                s_nxt.st = ST_WR;
                if (s_r.st == ST_ACK_WR) begin
                  s_nxt.ptr = s_r.ptr + 8'h01; // auto-increment
                end
              end
            end
          end
        end
        // register pointer byte
        ST_PTR: begin
          if (scl_rise) begin
            s_nxt.sh = sh_in;
            s_nxt.bitn = s_r.bitn + 3'h1;
            if (s_r.bitn == 3'h7) begin
              s_nxt.ptr = sh_in;
              s_nxt.st = ST_ACK_PTR;
            end
          end
        end
        // data byte: stored as one pulse once all eight bits are in
        ST_WR: begin
          if (scl_rise) begin
            s_nxt.sh = sh_in;
            s_nxt.bitn = s_r.bitn + 3'h1;
            if (s_r.bitn == 3'h7) begin
              s_nxt.wr_en = 1'b1;
              s_nxt.wr_data = sh_in;
              s_nxt.st = ST_ACK_WR;
            end
          end
        end
        // read byte shifted out msb first on falling edges; it is copied
        // at the ack release, so a later register change cannot tear it
        ST_RD: begin
          if (scl_fall) begin
            s_nxt.bitn = s_r.bitn + 3'h1;
            if (s_r.bitn == 3'h7) begin
              s_nxt.sda_oe_n = 1'b1;
              s_nxt.ptr = s_r.ptr + 8'h01;
              s_nxt.st = ST_ACK_RD;
            end else begin
              s_nxt.sh = {s_r.sh[6:0], 1'b0};
              s_nxt.sda_oe_n = s_r.sh[6];
            end
          end
        end
        // controller ack continues the read, nack ends it with the
        // line released, so a stop may follow straight away
        ST_ACK_RD: begin
          if (scl_rise) begin
            s_nxt.mack = ~sda_i;
          end else if (scl_fall) begin
            if (s_r.mack) begin
              s_nxt.st = ST_RD;
              s_nxt.bitn = 3'h0;
              s_nxt.sh = rd_data;
              s_nxt.sda_oe_n = rd_data[7];
            end else begin
              s_nxt.st = ST_IDLE;
            end
          end
        end
        default: begin
          s_nxt.st = ST_IDLE;
          s_nxt.sda_oe_n = 1'b1;
        end
      endcase
    end
  end

  // ==========================================================
  // state register; set-points start at the values the reset
  // register contents decode to, so outputs agree from the first cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r.st <= ST_IDLE;
      s_r.bitn <= 3'h0;
      s_r.sh <= 8'h00;
      s_r.ptr <= 8'h00;
      s_r.rw <= 1'b0;
      s_r.mack <= 1'b0;
      s_r.scl_q <= 1'b1;
      s_r.sda_q <= 1'b1;
      s_r.sda_o <= 1'b0;
      s_r.sda_oe_n <= 1'b1;
      s_r.wr_en <= 1'b0;
      s_r.wr_data <= 8'h00;
      s_r.term_ua <= TERM_LO_BASE_UA;
      s_r.term_act <= 1'b0;
      // regulation code 60 of the reset byte, 4.20 V
      s_r.batt_mv <= BATT_BASE_MV + 16'(CHGCFG_BATT_RST[BATT_CODE_HI:BATT_CODE_LO]) * BATT_STEP_MV;
      s_r.sys_en <= 1'b1;
      s_r.sys_pl <= 1'b0;
      s_r.sys_mv <= SYS_TBL_00[1];
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================
  // outputs straight from the state register
  assign sda_o = s_r.sda_o;
  assign sda_oe_n = s_r.sda_oe_n;
  assign term_current_ua = s_r.term_ua;
  assign term_active = s_r.term_act;
  assign battery_regulation_voltage = s_r.batt_mv;
  assign sys_out_enable = s_r.sys_en;
  assign sys_pull_low = s_r.sys_pl;
  assign system_rail_mv = s_r.sys_mv;

endmodule
`default_nettype wire

// ### tb/chgcfg_checker.sv
// pin-level checks for the charger configuration block
`timescale 1ns/1ps
`default_nettype none
module chgcfg_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_n,
  input wire logic cc_cv_in_control,
  input wire logic input_voltage_limit_loop,
  input wire logic cool_current_reduce,
  input wire logic ext_term_present,
  input wire logic [15:0] ext_term_ua,
  input wire logic [15:0] term_current_ua,
  input wire logic term_active,
  input wire logic [15:0] battery_regulation_voltage,
  input wire logic sys_out_enable,
  input wire logic sys_pull_low,
  input wire logic [15:0] system_rail_mv
);
  // ==========================================
  // one domain; checks rest while reset is high
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // second edge after release shows the decoded register defaults
  rst_outputs_a: assert property ($past(rst, 2) && !$past(rst) && !$past(ext_term_present) |->
    term_current_ua == 16'h01F4 && battery_regulation_voltage == 16'h1068 && system_rail_mv == 16'h04B0)
    else $error("outputs after reset differ from defaults");
  pull_low_a: assert property (sys_pull_low == !sys_out_enable)
    else $error("pull-low is not the inverse of enable");
  term_gate_a: assert property (term_active |-> $past(cc_cv_in_control) && !$past(input_voltage_limit_loop)
    && !$past(cool_current_reduce)) else $error("termination allowed under a foreign loop");
  ext_term_a: assert property (!$past(rst) && $past(ext_term_present) |-> term_current_ua == $past(ext_term_ua))
    else $error("external termination setting ignored");
  // off-grid values mean a wrong step, base or missing clamp
  term_set_a: assert property (!$past(ext_term_present) |-> term_current_ua inside {[16'h01F4:16'h1388]} &&
    term_current_ua % 16'h01F4 == 16'h0000 || term_current_ua inside {[16'h1770:16'h9088]} &&
    term_current_ua % 16'h03E8 == 16'h0000) else $error("termination current off its grid");
  batt_range_a: assert property (battery_regulation_voltage inside {[16'h0E10:16'h122A]} &&
    battery_regulation_voltage % 16'h000A == 16'h0000) else $error("regulation voltage off its grid");
  rail_range_a: assert property (system_rail_mv inside {[16'h044C:16'h0CE4]})
    else $error("rail voltage outside all ranges");
  // data may only move while the serial clock is low
  sda_timing_a: assert property ($changed(sda_oe_n) |-> !scl_i && !$past(scl_i))
    else $error("data line moved while clock high");
  sda_level_a: assert property (!sda_oe_n |-> sda_o == 1'b0)
    else $error("driven data level is not low");
endmodule

bind chgcfg_top chgcfg_checker i_chk (
  .clk(clk), .rst(rst), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
  .cc_cv_in_control(cc_cv_in_control), .input_voltage_limit_loop(input_voltage_limit_loop),
  .cool_current_reduce(cool_current_reduce), .ext_term_present(ext_term_present), .ext_term_ua(ext_term_ua),
  .term_current_ua(term_current_ua), .term_active(term_active),
  .battery_regulation_voltage(battery_regulation_voltage), .sys_out_enable(sys_out_enable),
  .sys_pull_low(sys_pull_low), .system_rail_mv(system_rail_mv)
);
`default_nettype wire

// ### tb/chgcfg_host.sv
// serial bus controller model driving the configuration port
`timescale 1ns/1ps
`default_nettype none
module chgcfg_host (
  input wire logic clk,
  input wire logic sda_in,
  output logic scl,
  output logic sda_rel
);
  // ==========================================
  // released lines read high through the bus pull-up
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end

  // one bit: data moves one clock after the fall, sampled late in the high phase
  task automatic xfer(input logic b, output logic r);
    @(posedge clk) sda_rel <= b;
    repeat (3) @(posedge clk);
    scl <= 1'b1;
    repeat (4) @(posedge clk);
    r = sda_in;
    scl <= 1'b0;
  endtask

  // start when stop is low, else stop; a start also serves as a repeated start
  task automatic edge_cond(input logic stop);
    @(posedge clk) sda_rel <= !stop;
    repeat (3) @(posedge clk);
    scl <= 1'b1;
    repeat (4) @(posedge clk);
    sda_rel <= stop;
    repeat (4) @(posedge clk);
    if (!stop) scl <= 1'b0;
  endtask

  task automatic byte_io(input logic [7:0] d, input logic a, output logic [7:0] q, output logic ak);
    for (int i = 7; i >= 0; i--) xfer(d[i], q[i]);
    xfer(a, ak);
  endtask

  // na holds the three acknowledge bits, high for a refused byte
  task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d, output logic [2:0] na);
    logic [7:0] q;
    edge_cond(1'b0);
    byte_io({a, 1'b0}, 1'b1, q, na[2]);
    byte_io(p, 1'b1, q, na[1]);
    byte_io(d, 1'b1, q, na[0]);
    edge_cond(1'b1);
  endtask

  task automatic rd(input logic [7:0] p, output logic [7:0] d, output logic [2:0] na);
    logic [7:0] q;
    logic x;
    edge_cond(1'b0);
    byte_io({chgcfg_pkg::CHGCFG_DEV_ADDR, 1'b0}, 1'b1, q, na[2]);
    byte_io(p, 1'b1, q, na[1]);
    edge_cond(1'b0);
    byte_io({chgcfg_pkg::CHGCFG_DEV_ADDR, 1'b1}, 1'b1, q, na[0]);
    byte_io(8'hFF, 1'b1, d, x);
    edge_cond(1'b1);
  endtask
endmodule
`default_nettype wire

// ### tb/chgcfg_tb_top.sv
// self-checking bench for the charger configuration block
`timescale 1ns/1ps
`default_nettype none
module chgcfg_tb_top;
  import chgcfg_pkg::*;
  logic clk, rst, cc, ivl, cool, ext_en, scl, sda_rel, sda_o, sda_oe_n, sda_wire;
  logic term_act, sys_en, sys_pl;
  logic [15:0] ext_ua, term_ua, batt_mv, rail_mv, res;
  logic [15:0] exp_q[$];
  logic [2:0] na;
  logic [6:0] ak;
  logic [7:0] q8, q9;
  logic nak;
  logic [31:0] r;
  event res_ev;
  int failures, checked, cyc;
  integer seed = 32'h31F4F6F6;
  // field boundaries: pointer in the upper byte, data in the lower
  logic [15:0] bnd[15] = '{16'h0424, 16'h0428, 16'h04FE, 16'h0483, 16'h0407, 16'h05D2, 16'h05D4, 16'h05FF,
    16'h0500, 16'h0501, 16'h0600, 16'h06BE, 16'h06DF, 16'h06E2, 16'h0661};

  // the wire is low if either party pulls it
  assign sda_wire = sda_rel & (sda_oe_n | sda_o);

  chgcfg_top i_dut (
    .clk(clk), .rst(rst), .scl_i(scl), .sda_i(sda_wire), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
    .cc_cv_in_control(cc), .input_voltage_limit_loop(ivl), .cool_current_reduce(cool),
    .ext_term_present(ext_en), .ext_term_ua(ext_ua), .term_current_ua(term_ua), .term_active(term_act),
    .battery_regulation_voltage(batt_mv), .sys_out_enable(sys_en), .sys_pull_low(sys_pl), .system_rail_mv(rail_mv)
  );
  chgcfg_host i_host (.clk(clk), .sda_in(sda_wire), .scl(scl), .sda_rel(sda_rel));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ==========================================
  // hang guard, well above the length of all frames
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      failures++;
      $display("[FAIL] %0t run hung", $time);
      summarize();
    end
  end

  // each posted result meets the oldest noted expectation
  initial begin
    forever begin
      @(res_ev);
      checked++;
      if (exp_q.size() == 0 || res !== exp_q.pop_front()) begin
        failures++;
        $display("[FAIL] %0t unexpected result %h", $time, res);
      end
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    exp_q.push_back(exp);
    @(posedge clk);
    res = got;
    -> res_ev;
  endtask

  // decoded pin value for a register write, from the field formulas
  function automatic logic [15:0] exp_out(input logic [7:0] p, input logic [7:0] d);
    logic [15:0] v;
    case (p)
      CHGCFG_TERM_OFS: begin
        v = d[7] ? TERM_HI_BASE_UA + 16'(d[6:2]) * TERM_HI_STEP_UA : TERM_LO_BASE_UA + 16'(d[6:2]) * TERM_LO_STEP_UA;
        if (!d[7] && v > TERM_LO_MAX_UA) v = TERM_LO_MAX_UA;
      end
      CHGCFG_BATT_OFS: begin
        v = BATT_BASE_MV + 16'(d[7:1]) * BATT_STEP_MV;
        if (v > BATT_MAX_MV) v = BATT_MAX_MV;
      end
      default: begin
        case (d[6:5])
          SYS_RANGE_SEL_00: v = SYS_TBL_00[d[4:1]];
          SYS_RANGE_SEL_01: v = SYS_R01_BASE_MV + 16'(d[4:1]) * SYS_STEP_MV;
          SYS_RANGE_SEL_10: v = SYS_TBL_10[d[4:1]];
          default: v = SYS_R11_BASE_MV + 16'(d[4:1]) * SYS_STEP_MV;
        endcase
      end
    endcase
    return v;
  endfunction

  // read back with all three bytes acknowledged
  task automatic rd_chk(input logic [7:0] p, input logic [7:0] e);
    logic [7:0] q;
    logic [2:0] a;
    i_host.rd(p, q, a);
    chk({q, 5'h00, a}, {e, 8'h00});
  endtask

  task automatic reg_case(input logic [7:0] p, input logic [7:0] d);
    logic [2:0] a;
    i_host.wr(CHGCFG_DEV_ADDR, p, d, a);
    chk(16'(a), 16'h0000);
    chk(p == CHGCFG_TERM_OFS ? term_ua : p == CHGCFG_BATT_OFS ? batt_mv : rail_mv, exp_out(p, d));
    if (p == CHGCFG_TERM_OFS) chk(16'(term_act), 16'(d[TERM_EN_BIT]));
    if (p == CHGCFG_SYS_OFS) chk(16'({sys_en, sys_pl}), 16'({d[7], !d[7]}));
    rd_chk(p, d);
  endtask

  task automatic summarize();
    $display("comparisons %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    rst = 1'b1;
    cc = 1'b1;
    ivl = 1'b0;
    cool = 1'b0;
    ext_en = 1'b0;
    ext_ua = 16'h0000;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    chk(term_ua, 16'h01F4);
    chk(batt_mv, 16'h1068);
    chk(rail_mv, 16'h04B0);
    rd_chk(CHGCFG_TERM_OFS, 8'h02);
    rd_chk(CHGCFG_BATT_OFS, 8'h78);
    rd_chk(CHGCFG_SYS_OFS, 8'h82);
    $display("test reset values done");
    foreach (bnd[i]) reg_case(bnd[i][15:8], bnd[i][7:0]);
    repeat (12) begin
      r = $random(seed);
      reg_case(CHGCFG_TERM_OFS + 8'(r[9:8] % 2'h3), r[7:0]);
    end
    // two data bytes in one frame, read back in one acked burst
    i_host.edge_cond(1'b0);
    i_host.byte_io({CHGCFG_DEV_ADDR, 1'b0}, 1'b1, q8, ak[0]);
    i_host.byte_io(CHGCFG_TERM_OFS, 1'b1, q8, ak[1]);
    i_host.byte_io(8'h06, 1'b1, q8, ak[2]);
    i_host.byte_io(8'h9F, 1'b1, q8, ak[3]);
    i_host.edge_cond(1'b0);
    i_host.byte_io({CHGCFG_DEV_ADDR, 1'b0}, 1'b1, q8, ak[4]);
    i_host.byte_io(CHGCFG_TERM_OFS, 1'b1, q8, ak[5]);
    i_host.edge_cond(1'b0);
    i_host.byte_io({CHGCFG_DEV_ADDR, 1'b1}, 1'b1, q8, ak[6]);
    i_host.byte_io(8'hFF, 1'b0, q8, nak);
    i_host.byte_io(8'hFF, 1'b1, q9, nak);
    i_host.edge_cond(1'b1);
    chk({q8, q9}, 16'h069F);
    chk(16'(ak), 16'h0000);
    $display("test field decode done");
    // every mix of loop states against an enabled termination
    reg_case(CHGCFG_TERM_OFS, 8'h02);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      {cc, ivl, cool} <= i[2:0];
      repeat (3) @(posedge clk);
      chk(16'(term_act), 16'(i == 4));
    end
    {cc, ivl, cool} <= 3'h4;
    ext_en <= 1'b1;
    ext_ua <= 16'($random(seed));
    repeat (3) @(posedge clk);
    chk(term_ua, ext_ua);
    chk(16'(term_act), 16'h0001);
    ext_en <= 1'b0;
    $display("test termination gating done");
    // unmapped place, then a foreign address that must leave the register alone
    reg_case(CHGCFG_BATT_OFS, 8'h5A);
    i_host.wr(CHGCFG_DEV_ADDR, 8'h10, 8'h55, na);
    chk(16'(na), 16'h0000);
    rd_chk(8'h10, CHGCFG_UNMAPPED_RD);
    i_host.wr(CHGCFG_DEV_ADDR ^ 7'h01, CHGCFG_BATT_OFS, 8'h00, na);
    chk(16'(na[2]), 16'h0001);
    rd_chk(CHGCFG_BATT_OFS, 8'h5A);
    $display("test address decode done");
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    chk(batt_mv, 16'h1068);
    rd_chk(CHGCFG_BATT_OFS, 8'h78);
    $display("test second reset done");
    @(posedge clk);
    summarize();
  end
endmodule
`default_nettype wire
